// ==== ltr_pkg.sv ====
// constants and types shared by the line thermal replica files
package ltr_pkg;
  // sampling and calculation step timing, scale factors and trip pulse length
  localparam int unsigned CLK_NS     = 50;
  localparam int unsigned SAMPLE_NS  = 1000000;
  localparam int unsigned SAMPLE_CYC = SAMPLE_NS / CLK_NS;
  localparam int unsigned RMS_WINDOW = 20;
  localparam int unsigned STEP_MS    = RMS_WINDOW * SAMPLE_NS / 1000000;
  localparam int unsigned MIN_TO_MS  = 60000;
  localparam logic [63:0] COEF_NUM   = (64'd1 << 32) * 64'(STEP_MS) / 64'(MIN_TO_MS);
  localparam logic [31:0] RATIO_MAX  = 32'h1000_0000;
  localparam logic [17:0] STU_SCALE  = 18'((32'd1 << 24) / 32'd100);
  localparam int unsigned CUR_PER_PCT = 10;
  localparam logic [3:0]  TRIP_PULSE_STEPS = 4'h5;
  // register offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_TEMPS  = 8'h04;
  localparam logic [7:0] ADDR_AUX    = 8'h08;
  localparam logic [7:0] ADDR_LOAD   = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_TEMPV  = 8'h14;
  // field positions
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned SENS_BIT = 2;
  localparam int unsigned FLD0 = 0;
  localparam int unsigned FLD1 = 8;
  localparam int unsigned FLD2 = 16;
  localparam int unsigned FLD3 = 24;
  localparam int unsigned ST_ALM_BIT = 0;
  localparam int unsigned ST_TRP_BIT = 1;
  localparam int unsigned ST_LCK_BIT = 2;
  // reset values and legal ranges of settings
  localparam logic [9:0] ALM_RST = 10'h050, ALM_MIN = 10'h03c, ALM_MAX = 10'h0c8;
  localparam logic [9:0] TRP_RST = 10'h064, TRP_MIN = 10'h03c, TRP_MAX = 10'h0c8;
  localparam logic [9:0] RAT_RST = 10'h064, RAT_MIN = 10'h03c, RAT_MAX = 10'h0c8;
  localparam logic [9:0] BAS_RST = 10'h019, BAS_MIN = 10'h000, BAS_MAX = 10'h028;
  localparam logic [9:0] UNL_RST = 10'h03c, UNL_MIN = 10'h014, UNL_MAX = 10'h0c8;
  localparam logic [9:0] AMB_RST = 10'h019, AMB_MIN = 10'h000, AMB_MAX = 10'h028;
  localparam logic [9:0] STU_RST = 10'h000, STU_MIN = 10'h000, STU_MAX = 10'h03c;
  localparam logic [9:0] RLC_RST = 10'h064, RLC_MIN = 10'h014, RLC_MAX = 10'h096;
  localparam logic [9:0] TC_RST  = 10'h00a, TC_MIN  = 10'h001, TC_MAX  = 10'h3e7;
  // operating modes and step sequencer states
  typedef enum logic [1:0] {LTR_MODE_OFF, LTR_MODE_PULSED, LTR_MODE_LOCKED} ltr_mode_t;
  typedef enum logic [2:0] {LTR_IDLE, LTR_DIV_RATIO, LTR_DIV_COEF,
                            LTR_UPDATE, LTR_DECIDE} ltr_fsm_t;
endpackage

// ==== ltr_rms_if.sv ====
// sample stream and sum-of-squares result between core and phase accumulator
`timescale 1ns/100ps
`default_nettype none
interface ltr_rms_if;
  logic signed [15:0] sample;
  logic               tick;
  logic [36:0]        ms;
  logic               ms_vld;
  modport src (output sample, output tick, input ms, input ms_vld);
  modport acc (input sample, input tick, output ms, output ms_vld);
endinterface
`default_nettype wire

// ==== ltr_rms_acc.sv ====
// per-phase sum of squares over one calculation window
`timescale 1ns/100ps
`default_nettype none
module ltr_rms_acc (
  input  wire logic clock,
  input  wire logic rst_n,
  ltr_rms_if.acc    pin
);
  import ltr_pkg::*;

  typedef struct packed {
    logic [36:0] acc;
    logic [4:0]  n;
    logic [36:0] ms;
    logic        vld;
  } ltr_rms_st_t;

  ltr_rms_st_t st_r;
  ltr_rms_st_t st_nxt;
  logic [31:0] sq;

  // square the sample, accumulate, emit at end of window
  always_comb begin
    st_nxt = st_r;
    st_nxt.vld = 1'b0;
    sq = 32'($signed(pin.sample)) * 32'($signed(pin.sample));
    if (pin.tick) begin
      if (st_r.n == 5'(RMS_WINDOW - 1)) begin
        st_nxt.ms  = st_r.acc + 37'(sq);
        st_nxt.acc = '0;
        st_nxt.n   = '0;
        st_nxt.vld = 1'b1;
      end else begin
        st_nxt.acc = st_r.acc + 37'(sq);
        st_nxt.n   = st_r.n + 5'h1;
      end
    end
  end

  // state register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin.ms     = st_r.ms;
  assign pin.ms_vld = st_r.vld;

  window_bound_a: assert property (@(posedge clock) disable iff (!rst_n)
    st_r.n < 5'(RMS_WINDOW)) else $error("rms window count out of range");
endmodule // ltr_rms_acc
`default_nettype wire

// ==== ltr_core.sv ====
// line thermal replica: rms, max select, thermal recursion, decisions, apb
`timescale 1ns/100ps
`default_nettype none
module ltr_core #(
  parameter int unsigned SAMPLE_CYCLES = ltr_pkg::SAMPLE_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] phase_a_current,
  input  wire logic [15:0] phase_b_current,
  input  wire logic [15:0] phase_c_current,
  input  wire logic [7:0]  ambient_temp_in,
  input  wire logic        function_block_in,
  input  wire logic        heat_reset_in,
  output logic             sample_tick,
  output logic             thermal_alarm_out,
  output logic             thermal_trip_out,
  output logic             reclose_lock_out,
  output logic [23:0]      calculated_temp_value
);
  import ltr_pkg::*;

  typedef struct packed {
    ltr_mode_t   mode;
    logic        sens;
    logic [7:0]  alm, trp, rat, bas, unl, amb, stu, rlc;
    logic [9:0]  tc;
    logic [31:0] rdat;
    logic        err;
    logic [14:0] tcnt;
    logic        tick;
    ltr_fsm_t    fsm;
    logic [6:0]  cnt;
    logic [63:0] dvd;
    logic [27:0] rem;
    logic [26:0] dvs;
    logic [63:0] quo;
    logic [36:0] sel;
    logic [31:0] ratio, coef, heat;
    logic [23:0] temp;
    logic        init;
    logic        alm_o, trp_o, lck_o, lock_l, armed;
    logic [3:0]  pcnt;
  } ltr_core_st_t;

  ltr_core_st_t st_r;
  ltr_core_st_t st_nxt;

  logic [15:0] cur_w [3];
  logic [36:0] ms_w [3];
  logic [2:0]  vld_w;
  logic [36:0] sel_c;
  logic [31:0] start_c;
  logic [7:0]  amb_c;
  logic [39:0] rise_c;
  logic [23:0] tmp_c;
  logic        ovr_trp, ovr_alm, blw_unl, quiet;
  logic        wr_acc, rd_setup;

  function automatic logic [9:0] lim(logic [9:0] v, logic [9:0] lo, logic [9:0] hi);
    if (v < lo) return lo;
    if (v > hi) return hi;
    return v;
  endfunction

  assign cur_w[0] = phase_a_current;
  assign cur_w[1] = phase_b_current;
  assign cur_w[2] = phase_c_current;

  // one accumulator per phase
  for (genvar i = 0; i < 3; i++) begin : g_ph
    ltr_rms_if u_if ();
    assign u_if.sample = cur_w[i];
    assign u_if.tick   = st_r.tick;
    ltr_rms_acc u_acc (
      .clock (clock),
      .rst_n (rst_n),
      .pin   (u_if.acc)
    );
    assign ms_w[i]  = u_if.ms;
    assign vld_w[i] = u_if.ms_vld;
  end

  // derived values for the step
  always_comb begin
    sel_c = ms_w[0];
    if (ms_w[1] > sel_c) sel_c = ms_w[1];
    if (ms_w[2] > sel_c) sel_c = ms_w[2];
    start_c = 32'(st_r.stu) * 32'(STU_SCALE);
    amb_c = st_r.sens ? ambient_temp_in : st_r.amb;
    // rise scaled by rated minus base
    rise_c = 40'(st_r.heat) * 40'(st_r.rat - st_r.bas);
    tmp_c = rise_c[39:16] + {8'h00, amb_c, 8'h00};
    ovr_trp = tmp_c > {8'h00, st_r.trp, 8'h00};
    ovr_alm = tmp_c > {8'h00, st_r.alm, 8'h00};
    blw_unl = tmp_c < {8'h00, st_r.unl, 8'h00};
    quiet = (st_r.mode == LTR_MODE_OFF) || function_block_in;
  end

  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable;

  // next state of registers, sequencer and decisions
  always_comb begin
    logic [27:0] r2;
    logic signed [33:0] diff;
    logic signed [55:0] prod;
    logic signed [55:0] hn;
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    r2 = '0;
    diff = '0;
    prod = '0;
    hn = '0;
    // sample strobe at the 1 kHz rate
    if (st_r.tcnt == 15'(SAMPLE_CYCLES - 1)) begin
      st_nxt.tcnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.tcnt = st_r.tcnt + 15'h1;
    end
    // apb read data captured in setup phase
    if (rd_setup) begin
      st_nxt.err  = 1'b0;
      st_nxt.rdat = '0;
      if (paddr == ADDR_CTRL) begin
        st_nxt.rdat[MODE_LSB +: 2] = st_r.mode;
        st_nxt.rdat[SENS_BIT]      = st_r.sens;
      end else if (paddr == ADDR_TEMPS) begin
        st_nxt.rdat = {st_r.bas, st_r.rat, st_r.trp, st_r.alm};
      end else if (paddr == ADDR_AUX) begin
        st_nxt.rdat = {8'h00, st_r.stu, st_r.amb, st_r.unl};
      end else if (paddr == ADDR_LOAD) begin
        st_nxt.rdat[FLD0 +: 8]  = st_r.rlc;
        st_nxt.rdat[FLD2 +: 10] = st_r.tc;
      end else if (paddr == ADDR_STATUS) begin
        st_nxt.rdat[ST_ALM_BIT] = st_r.alm_o;
        st_nxt.rdat[ST_TRP_BIT] = st_r.trp_o;
        st_nxt.rdat[ST_LCK_BIT] = st_r.lck_o;
      end else if (paddr == ADDR_TEMPV) begin
        st_nxt.rdat = {8'h00, st_r.temp};
      end else begin
        st_nxt.err = 1'b1;
      end
    end
    // apb writes, settings clamped to range
    if (wr_acc) begin
      if (paddr == ADDR_CTRL) begin
        if (pwdata[MODE_LSB +: 2] != 2'h3) begin
          st_nxt.mode = ltr_mode_t'(pwdata[MODE_LSB +: 2]);
        end
        st_nxt.sens = pwdata[SENS_BIT];
      end else if (paddr == ADDR_TEMPS) begin
        st_nxt.alm = 8'(lim({2'b00, pwdata[FLD0 +: 8]}, ALM_MIN, ALM_MAX));
        st_nxt.trp = 8'(lim({2'b00, pwdata[FLD1 +: 8]}, TRP_MIN, TRP_MAX));
        st_nxt.rat = 8'(lim({2'b00, pwdata[FLD2 +: 8]}, RAT_MIN, RAT_MAX));
        st_nxt.bas = 8'(lim({2'b00, pwdata[FLD3 +: 8]}, BAS_MIN, BAS_MAX));
      end else if (paddr == ADDR_AUX) begin
        st_nxt.unl = 8'(lim({2'b00, pwdata[FLD0 +: 8]}, UNL_MIN, UNL_MAX));
        st_nxt.amb = 8'(lim({2'b00, pwdata[FLD1 +: 8]}, AMB_MIN, AMB_MAX));
        st_nxt.stu = 8'(lim({2'b00, pwdata[FLD2 +: 8]}, STU_MIN, STU_MAX));
      end else if (paddr == ADDR_LOAD) begin
        st_nxt.rlc = 8'(lim({2'b00, pwdata[FLD0 +: 8]}, RLC_MIN, RLC_MAX));
        st_nxt.tc  = lim(pwdata[FLD2 +: 10], TC_MIN, TC_MAX);
      end
    end
    // one calculation step per rms window
    case (st_r.fsm)
      LTR_IDLE: begin
        if (vld_w[0]) begin
          st_nxt.sel = sel_c;
          st_nxt.dvd = {3'b000, sel_c, 24'h000000};
          st_nxt.dvs = 27'(32'(st_r.rlc) * 32'(st_r.rlc)
                       * 32'(CUR_PER_PCT * CUR_PER_PCT * RMS_WINDOW));
          st_nxt.rem = '0;
          st_nxt.quo = '0;
          st_nxt.cnt = 7'h3f;
          st_nxt.fsm = LTR_DIV_RATIO;
        end
      end
      LTR_DIV_RATIO, LTR_DIV_COEF: begin
        // shared restoring divider, one quotient bit per clock
        r2 = {st_r.rem[26:0], st_r.dvd[63]};
        st_nxt.dvd = {st_r.dvd[62:0], 1'b0};
        if (r2 >= {1'b0, st_r.dvs}) begin
          st_nxt.rem = r2 - {1'b0, st_r.dvs};
          st_nxt.quo = {st_r.quo[62:0], 1'b1};
        end else begin
          st_nxt.rem = r2;
          st_nxt.quo = {st_r.quo[62:0], 1'b0};
        end
        st_nxt.cnt = st_r.cnt - 7'h1;
        if (st_r.cnt == 7'h0) begin
          if (st_r.fsm == LTR_DIV_RATIO) begin
            // squared current ratio, q24, saturated
            st_nxt.ratio = (st_nxt.quo > 64'(RATIO_MAX)) ? RATIO_MAX
                           : st_nxt.quo[31:0];
            st_nxt.dvd = COEF_NUM;
            st_nxt.dvs = 27'(st_r.tc);
            st_nxt.rem = '0;
            st_nxt.quo = '0;
            st_nxt.cnt = 7'h3f;
            st_nxt.fsm = LTR_DIV_COEF;
          end else begin
            st_nxt.coef = st_nxt.quo[31:0];
            st_nxt.fsm  = LTR_UPDATE;
          end
        end
      end
      LTR_UPDATE: begin
        // H += dt/T * (ratio - H)
        diff = $signed({2'b00, st_r.ratio}) - $signed({2'b00, st_r.heat});
        // q32 coefficient keeps step error tiny
        prod = 56'(diff) * 56'($signed({1'b0, st_r.coef[20:0]}));
        hn = $signed({24'h000000, st_r.heat}) + (prod >>> 32);
        st_nxt.heat = hn[31:0];
        st_nxt.fsm  = LTR_DECIDE;
      end
      LTR_DECIDE: begin
        st_nxt.temp = tmp_c;
        st_nxt.alm_o = ovr_alm;
        // lock latch between trip and unlock
        if (ovr_trp) begin
          st_nxt.lock_l = 1'b1;
        end else if (blw_unl) begin
          st_nxt.lock_l = 1'b0;
        end
        if (ovr_trp && st_r.armed) begin
          st_nxt.pcnt  = TRIP_PULSE_STEPS;
          st_nxt.armed = 1'b0;
        end else if (st_r.pcnt != 4'h0) begin
          st_nxt.pcnt = st_r.pcnt - 4'h1;
        end
        if (!ovr_trp) st_nxt.armed = 1'b1;
        if (st_r.mode == LTR_MODE_LOCKED) begin
          st_nxt.trp_o = st_nxt.lock_l;
        end else begin
          st_nxt.trp_o = st_nxt.pcnt != 4'h0;
        end
        st_nxt.lck_o = st_nxt.lock_l;
        st_nxt.fsm   = LTR_IDLE;
      end
      default: st_nxt.fsm = LTR_IDLE;
    endcase
    // heat reset loads the startup level
    if (st_r.init || heat_reset_in) begin
      st_nxt.heat = start_c;
      st_nxt.init = 1'b0;
    end
    // block or off silences and clears
    if (quiet) begin
      st_nxt.alm_o  = 1'b0;
      st_nxt.trp_o  = 1'b0;
      st_nxt.lck_o  = 1'b0;
      st_nxt.lock_l = 1'b0;
      st_nxt.pcnt   = 4'h0;
      st_nxt.armed  = 1'b1;
    end
  end

  // state register with documented defaults
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r       <= '0;
      st_r.mode  <= LTR_MODE_PULSED;
      st_r.alm   <= 8'(ALM_RST);
      st_r.trp   <= 8'(TRP_RST);
      st_r.rat   <= 8'(RAT_RST);
      st_r.bas   <= 8'(BAS_RST);
      st_r.unl   <= 8'(UNL_RST);
      st_r.amb   <= 8'(AMB_RST);
      st_r.stu   <= 8'(STU_RST);
      st_r.rlc   <= 8'(RLC_RST);
      st_r.tc    <= TC_RST;
      st_r.fsm   <= LTR_IDLE;
      st_r.armed <= 1'b1;
      st_r.init  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // apb answer, zero wait states
  assign pready  = psel && penable;
  assign pslverr = psel && penable && st_r.err;
  assign prdata  = st_r.rdat;
  // status outputs
  assign sample_tick           = st_r.tick;
  assign thermal_alarm_out     = st_r.alm_o;
  assign thermal_trip_out      = st_r.trp_o;
  assign reclose_lock_out      = st_r.lck_o;
  assign calculated_temp_value = st_r.temp;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  off_quiet_a: assert property ((st_r.mode == LTR_MODE_OFF) |=>
    !thermal_alarm_out && !thermal_trip_out && !reclose_lock_out)
    else $error("output active in off mode");
  block_quiet_a: assert property (function_block_in |=>
    !thermal_alarm_out && !thermal_trip_out && !reclose_lock_out)
    else $error("output active while blocked");
  heat_reset_a: assert property (heat_reset_in |=>
    st_r.heat == $past(start_c)) else $error("heat reset not applied");
  max_select_a: assert property (st_r.fsm == LTR_DIV_RATIO && st_r.cnt == 7'h3f |->
    st_r.sel >= ms_w[0] && st_r.sel >= ms_w[1] && st_r.sel >= ms_w[2]
    && st_r.dvd == {3'b000, st_r.sel, 24'h000000})
    else $error("selected current not the maximum");
  coef_value_a: assert property ((st_r.fsm == LTR_UPDATE) |->
    64'(st_r.coef) * 64'(st_r.tc) <= COEF_NUM
    && (64'(st_r.coef) + 64'h1) * 64'(st_r.tc) > COEF_NUM)
    else $error("step coefficient wrong");
  step_latency_a: assert property (vld_w[0] && st_r.fsm == LTR_IDLE |->
    ##130 st_r.fsm == LTR_DECIDE) else $error("step did not complete");
  // pulse starts when trip level passed
  pulse_start_a: assert property (st_r.fsm == LTR_DECIDE &&
    st_r.mode == LTR_MODE_PULSED && st_r.armed && ovr_trp && !quiet
    |=> thermal_trip_out && !st_r.armed) else $error("trip pulse missing");
  pulse_len_a: assert property (st_r.pcnt <= TRIP_PULSE_STEPS)
    else $error("trip pulse counter too large");
  lock_hold_a: assert property (st_r.mode == LTR_MODE_LOCKED &&
    thermal_trip_out && !blw_unl && !quiet && !wr_acc |=> thermal_trip_out)
    else $error("locked trip released early");

  trip_seen_c: cover property ($rose(thermal_trip_out));
  alarm_seen_c: cover property ($rose(thermal_alarm_out));
  lock_clear_c: cover property ($fell(reclose_lock_out) && !function_block_in);
  reset_heat_c: cover property (heat_reset_in && st_r.heat != start_c);
endmodule // ltr_core
`default_nettype wire

// ==== ltr_fe.sv ====
// phase current front end model: square wave samples per phase
`timescale 1ns/100ps
`default_nettype none
module ltr_fe (
  input  wire logic        clock,
  input  wire logic        sample_tick,
  input  wire logic [15:0] amp_a,
  input  wire logic [15:0] amp_b,
  input  wire logic [15:0] amp_c,
  output logic [15:0]      phase_a_current,
  output logic [15:0]      phase_b_current,
  output logic [15:0]      phase_c_current
);
  logic pol_r = 1'b0;
  // sign flips after each taken sample, so rms equals amplitude
  always @(posedge clock) begin
    if (sample_tick) begin
      pol_r <= ~pol_r;
    end
  end
  // valid samples are presented at every tick
  assign phase_a_current = pol_r ? -amp_a : amp_a;
  assign phase_b_current = pol_r ? -amp_b : amp_b;
  assign phase_c_current = pol_r ? -amp_c : amp_c;
endmodule // ltr_fe
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the line thermal replica core
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ltr_pkg::*;
  localparam int unsigned SC = 20;
  localparam real         KD = real'(MIN_TO_MS) / real'(STEP_MS);
  logic        clock, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        blk, hrst, tick, alm, trp, lck, er;
  logic [7:0]  paddr, amb;
  logic [31:0] pwdata, prdata, rd, outs;
  logic [15:0] ia, ib, ic, aa, ab, ac;
  logic [23:0] tv;
  int          fails, total_checks, n, p, a;
  real         r;

  assign outs = {29'h0, alm, trp, lck};

  ltr_core #(.SAMPLE_CYCLES(SC)) uut (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .phase_a_current(ia),
    .phase_b_current(ib), .phase_c_current(ic), .ambient_temp_in(amb),
    .function_block_in(blk), .heat_reset_in(hrst), .sample_tick(tick),
    .thermal_alarm_out(alm), .thermal_trip_out(trp),
    .reclose_lock_out(lck), .calculated_temp_value(tv)
  );

  ltr_fe fe (
    .clock(clock), .sample_tick(tick), .amp_a(aa), .amp_b(ab),
    .amp_c(ac), .phase_a_current(ia), .phase_b_current(ib),
    .phase_c_current(ic)
  );

  // clock, 50 ns period
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task results;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one apb transfer, held until pready is seen high
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task heat_rst;
    @(posedge clock);
    hrst <= 1'b1;
    repeat (3) @(posedge clock);
    hrst <= 1'b0;
  endtask

  task steps(input int k);
    repeat (k * 20) @(posedge clock iff tick);
    repeat (150) @(posedge clock);
  endtask

  // load aux settings, restart heat, then compare the three outputs
  task lvl(input logic [31:0] aux, input logic [31:0] e);
    apb(1'b1, ADDR_AUX, aux);
    heat_rst();
    steps(2);
    check(outs, e);
  endtask

  function automatic real heat(input real rr, input int k);
    real h;
    h = 0.0;
    repeat (k) begin
      h = h * (1.0 - 1.0 / KD) + rr / KD;
    end
    return h;
  endfunction

  // accepts the seen degrees when within 1.5 of the model
  function automatic logic [31:0] near(input logic [23:0] t, input real e);
    real s;
    s = t / 256.0;
    if (!$isunknown(t) && s - e <= 1.5 && e - s <= 1.5) begin
      return 32'(t[23:8]);
    end
    return 32'($rtoi(e));
  endfunction

  // watchdog
  initial begin
    repeat (60000) @(posedge clock);
    fails++;
    results();
  end

  initial begin
    {rst_n, psel, penable, pwrite, blk, hrst} = '0;
    paddr = '0;
    pwdata = '0;
    amb = '0;
    {aa, ab, ac} = '0;
    fails = 0;
    total_checks = 0;
    void'($urandom(32'h813d));
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_CTRL, 0);
    check(rd & 32'h7, 32'h1);
    apb(1'b0, ADDR_TEMPS, 0);
    check(rd, 32'h19646450);
    apb(1'b0, ADDR_LOAD, 0);
    check(rd & 32'h03ff00ff, 32'h000a0064);
    apb(1'b0, 8'h20, 0);
    check({31'h0, er}, 32'h1);
    $display("test defaults done");
    // clamping, time constant 1 min, load current 20 %
    apb(1'b1, ADDR_TEMPS, 32'h1964ff0a);
    apb(1'b0, ADDR_TEMPS, 0);
    check(rd, 32'h1964c83c);
    apb(1'b1, ADDR_LOAD, 32'h00000014);
    apb(1'b0, ADDR_LOAD, 0);
    check(rd & 32'h03ff00ff, 32'h00010014);
    apb(1'b1, ADDR_CTRL, 32'h7);
    apb(1'b0, ADDR_CTRL, 0);
    check(rd & 32'h7, 32'h5);
    // measured ambient at random values
    repeat (3) begin
      amb <= 8'($urandom_range(40, 0));
      heat_rst();
      steps(2);
      check(32'(tv), {16'h0, amb, 8'h0});
    end
    $display("test settings done");
    // locked mode: trip 60, alarm 65, startup 60 % gives 70 deg
    apb(1'b1, ADDR_TEMPS, 32'h19643c41);
    apb(1'b1, ADDR_CTRL, 32'h2);
    lvl(32'h003c1914, 32'h7);
    check(32'(tv[23:8]), near(tv, 70.0));
    apb(1'b0, ADDR_STATUS, 0);
    check(rd & 32'h7, 32'h7);
    lvl(32'h00001914, 32'h3);
    lvl(32'h00001920, 32'h0);
    lvl(32'h003c1914, 32'h7);
    blk <= 1'b1;
    repeat (3) @(posedge clock);
    check(outs, 32'h0);
    blk <= 1'b0;
    steps(2);
    check(outs, 32'h7);
    apb(1'b1, ADDR_CTRL, 32'h0);
    steps(2);
    check(outs, 32'h0);
    $display("test locked done");
    // pulsed trip length and re-arm
    apb(1'b1, ADDR_CTRL, 32'h1);
    lvl(32'h00001914, 32'h0);
    apb(1'b1, ADDR_AUX, 32'h003c1914);
    heat_rst();
    while (trp !== 1'b1) begin
      @(posedge clock);
    end
    n = 0;
    while (trp === 1'b1) begin
      @(posedge clock);
      n++;
    end
    check(32'(n), 32'(5 * 20 * SC));
    steps(6);
    check(outs, 32'h5);
    // cool below trip to re-arm, then heat again for a second pulse
    lvl(32'h00001914, 32'h1);
    lvl(32'h003c1914, 32'h7);
    $display("test pulsed done");
    // heating from the largest phase, others at half amplitude
    apb(1'b1, ADDR_AUX, 32'h00001914);
    repeat (2) begin
      p = $urandom_range(2, 0);
      a = $urandom_range(800, 400);
      aa <= 16'(p == 0 ? a : a / 2);
      ab <= 16'(p == 1 ? a : a / 2);
      ac <= 16'(p == 2 ? a : a / 2);
      r = (a / (20.0 * CUR_PER_PCT)) * (a / (20.0 * CUR_PER_PCT));
      heat_rst();
      steps(10);
      check(32'(tv[23:8]), near(tv, heat(r, 10) * 75.0 + 25.0));
    end
    $display("test heating done");
    results();
  end
endmodule // tb
`default_nettype wire
